// >>> hw/spm_defines.svh
// Constants for the serial control pin multiplexer
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH
`define SPM_NUM_PINS 3
`define SPM_IDX_CTRL0 0
`define SPM_IDX_CTRL1 1
`define SPM_IDX_CTRL2 2
`define SPM_RST_SEL 3'h0
`define SPM_RST_DIR 3'h0
`define SPM_RST_OUT 3'h0
`define SPM_RST_SYNC 1'h0
`define SPM_RST_FLAG_IN 3'h0
`define SPM_RST_FSYNC_IN 1'h0
`define SPM_RST_PORT_IN 3'h0
`endif

// >>> hw/spm_pkg.sv
// Types for the serial control pin multiplexer
package spm_pkg;
	// Per-pin drive request from the serial interface or from port logic
	typedef struct packed {
		logic [2:0] dout;
		logic [2:0] oe;
	} spm_drive_t;
	// Serial clocking mode as the serial interface sees it
	typedef enum logic [1:0] {
		SPM_MODE_ASYNC = 2'h1,
		SPM_MODE_SYNC = 2'h2
	} spm_mode_t;
endpackage : spm_pkg

// >>> hw/spm_pin_mux.sv
// Pin function selection for serial control pins 0..2 and port bits
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`include "spm_defines.svh"

module spm_pin_mux
	import spm_pkg::*;
#(
	parameter int NUM_PINS = `SPM_NUM_PINS
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic sync_mode,
	input wire logic [2:0] serial_sel,
	input wire logic [2:0] flag_out,
	input wire logic [2:0] flag_dir,
	input wire logic fsync_out,
	input wire logic fsync_dir,
	input wire logic [2:0] port_out,
	input wire logic [2:0] port_dir,
	input wire logic [2:0] pin_in,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe,
	output logic [2:0] flag_in,
	output logic fsync_in,
	output logic [2:0] port_in
);

	//------------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------------
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;

	// Pads move with no regard for the clock, so each pin gets two
	// stages; only the second stage is read, the first may be unsettled
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin_sync
		always_ff @(posedge clock) begin
			if (reset) begin
				pin_meta_q[i] <= `SPM_RST_SYNC;
				pin_sync_q[i] <= `SPM_RST_SYNC;
			end else begin
				pin_meta_q[i] <= pin_in[i];
				pin_sync_q[i] <= pin_meta_q[i];
			end
		end
	end

	//------------------------------------------------------------------
	// Function decode
	//------------------------------------------------------------------
	// Serial role of each pin; control 1 splits again on the clocking
	wire ctrl0_is_flag = serial_sel[`SPM_IDX_CTRL0];
	// Control 1 is frame sync in async mode, a flag in sync mode
	wire ctrl1_is_fsync = serial_sel[`SPM_IDX_CTRL1] & ~sync_mode;
	wire ctrl1_is_flag = serial_sel[`SPM_IDX_CTRL1] & sync_mode;
	// Control 2 has no flag role, so its mode bit is not consulted
	wire ctrl2_is_fsync = serial_sel[`SPM_IDX_CTRL2];
	// A net, so that each pin's slice can carry its own assignment
	wire spm_drive_t drive_d;

	// Control 0 flag path; independent from control 1
	assign drive_d.dout[0] = serial_sel[0] ? flag_out[0] : port_out[0];
	assign drive_d.oe[0] = serial_sel[0] ? flag_dir[0] : port_dir[0];
	// Control 1: frame sync, flag, or port bit 4
	assign drive_d.dout[1] = ctrl1_is_fsync ? fsync_out :
		ctrl1_is_flag ? flag_out[1] : port_out[1];
	assign drive_d.oe[1] = ctrl1_is_fsync ? fsync_dir :
		ctrl1_is_flag ? flag_dir[1] : port_dir[1];
	// Control 2 carries frame sync only, else port bit 5
	assign drive_d.dout[2] = serial_sel[2] ? fsync_out : port_out[2];
	assign drive_d.oe[2] = serial_sel[2] ? fsync_dir : port_dir[2];

	// Each reader sees a pin only while the pin holds its role, so a
	// port read never shows serial traffic and the reverse
	wire [2:0] flag_in_d = {1'h0, pin_sync_q[1] & ctrl1_is_flag,
		pin_sync_q[0] & ctrl0_is_flag};
	// Control 2 wins if both pins were given frame sync at once
	wire fsync_in_d = ctrl2_is_fsync ? pin_sync_q[2] :
		(ctrl1_is_fsync & pin_sync_q[1]);
	wire [2:0] port_in_d = pin_sync_q & ~serial_sel;

	//------------------------------------------------------------------
	// Output registers
	//------------------------------------------------------------------
	// Reset values make every pin a released port input; registering
	// the pad controls costs a cycle but keeps glitches off the pins
	always_ff @(posedge clock) begin
		if (reset) begin
			pin_out <= `SPM_RST_OUT;
			pin_oe <= `SPM_RST_DIR;
			flag_in <= `SPM_RST_FLAG_IN;
			fsync_in <= `SPM_RST_FSYNC_IN;
			port_in <= `SPM_RST_PORT_IN;
		end else begin
			pin_out <= drive_d.dout;
			pin_oe <= drive_d.oe;
			flag_in <= flag_in_d;
			fsync_in <= fsync_in_d;
			port_in <= port_in_d;
		end
	end

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	//------------------------------------------------------------------
	// Checks: reset
	//------------------------------------------------------------------
	// Any edge in reset leaves every output at its idle value
	a_reset_clear: assert property (@(posedge clock)
		reset |=> pin_oe == 3'h0 && pin_out == 3'h0 &&
		flag_in == 3'h0 && port_in == 3'h0 && !fsync_in)
		else $error("outputs not idle in reset");

	// Leaving reset, the pads are still released port inputs
	a_reset_input: assert property (@(posedge clock)
		$fell(reset) |-> pin_oe == 3'h0 && pin_out == 3'h0)
		else $error("pins not released after reset");

	//------------------------------------------------------------------
	// Checks: pad drive
	//------------------------------------------------------------------
	// Control 0 as a flag carries the flag value and direction
	a_ctrl0_flag: assert property (@(posedge clock)
		disable iff (reset)
		serial_sel[0] |=> pin_out[0] == $past(flag_out[0]) &&
		pin_oe[0] == $past(flag_dir[0]))
		else $error("control 0 flag wrong");

	// Asynchronous clocking turns control 1 into frame sync
	a_ctrl1_fsync: assert property (@(posedge clock)
		disable iff (reset)
		(serial_sel[1] && !sync_mode) |=>
		pin_oe[1] == $past(fsync_dir) && pin_out[1] == $past(fsync_out))
		else $error("control 1 not frame sync in async");

	// Synchronous clocking turns control 1 into a flag
	a_ctrl1_flag: assert property (@(posedge clock)
		disable iff (reset)
		(serial_sel[1] && sync_mode) |=>
		pin_out[1] == $past(flag_out[1]) && pin_oe[1] == $past(flag_dir[1]))
		else $error("control 1 not flag in sync");

	// The clocking mode alone decides which role control 1 takes
	a_ctrl1_mode: assert property (@(posedge clock)
		disable iff (reset)
		serial_sel[1] |=> pin_out[1] == ($past(sync_mode) ?
		$past(flag_out[1]) : $past(fsync_out)))
		else $error("control 1 role wrong");

	// Both flags at once still follow their own inputs bit by bit
	a_flag_indep: assert property (@(posedge clock)
		disable iff (reset)
		(serial_sel[0] && serial_sel[1] && sync_mode) |=>
		pin_out[1:0] == $past(flag_out[1:0]) &&
		pin_oe[1:0] == $past(flag_dir[1:0]))
		else $error("flags not independent");

	// Without its serial role the control 1 pin is port bit 4
	a_port_bit4: assert property (@(posedge clock)
		disable iff (reset)
		!serial_sel[1] |=> pin_out[1] == $past(port_out[1]) &&
		pin_oe[1] == $past(port_dir[1]))
		else $error("port bit 4 wrong");

	// Control 2 only ever carries frame sync
	a_ctrl2_fsync: assert property (@(posedge clock)
		disable iff (reset)
		serial_sel[2] |=> pin_out[2] == $past(fsync_out) &&
		pin_oe[2] == $past(fsync_dir))
		else $error("control 2 not frame sync");

	// Without its serial role the control 2 pin is port bit 5
	a_port_bit5: assert property (@(posedge clock)
		disable iff (reset)
		!serial_sel[2] |=> pin_oe[2] == $past(port_dir[2]) &&
		pin_out[2] == $past(port_out[2]))
		else $error("port bit 5 wrong");

	// Control 0 in port role follows the port direction and value
	a_port_bit0: assert property (@(posedge clock)
		disable iff (reset)
		!serial_sel[0] |=> pin_out[0] == $past(port_out[0]) &&
		pin_oe[0] == $past(port_dir[0]))
		else $error("port bit on control 0 wrong");

	//------------------------------------------------------------------
	// Checks: pad release
	//------------------------------------------------------------------
	// A port input on control 0 must leave the pad undriven
	a_input_release: assert property (@(posedge clock)
		disable iff (reset)
		(!serial_sel[0] && !port_dir[0]) |=> !pin_oe[0])
		else $error("input pin driven");

	// Frame sync input on control 1 must leave the pad undriven
	a_ctrl1_release: assert property (@(posedge clock)
		disable iff (reset)
		(serial_sel[1] && !sync_mode && !fsync_dir) |=> !pin_oe[1])
		else $error("control 1 input driven");

	// Frame sync input on control 2 must leave the pad undriven
	a_ctrl2_release: assert property (@(posedge clock)
		disable iff (reset)
		(serial_sel[2] && !fsync_dir) |=> !pin_oe[2])
		else $error("control 2 input driven");

	//------------------------------------------------------------------
	// Checks: pad read
	//------------------------------------------------------------------
	// Port reads show nothing of pins that are in a serial role
	a_port_in_mask: assert property (@(posedge clock)
		disable iff (reset)
		serial_sel != 3'h0 |=> (port_in & $past(serial_sel)) == 3'h0)
		else $error("port read shows serial pin");

	// Control 1 reads as a flag only in synchronous clocking
	a_flag_in_mask: assert property (@(posedge clock)
		disable iff (reset)
		!(serial_sel[1] && sync_mode) |=> !flag_in[1])
		else $error("control 1 flag read out of role");

	// Selected control 2 is the frame sync source
	a_fsync_src: assert property (@(posedge clock)
		disable iff (reset)
		serial_sel[2] |=> fsync_in == $past(pin_sync_q[2]))
		else $error("frame sync not read from control 2");

	// In synchronous clocking control 1 gives no frame sync
	a_fsync_sync_mode: assert property (@(posedge clock)
		disable iff (reset)
		(!serial_sel[2] && sync_mode) |=> !fsync_in)
		else $error("frame sync read in sync mode");

endmodule : spm_pin_mux

// >>> bench/spm_far_dev.sv
// Far-side serial device model for the shared control pins
module spm_far_dev (
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	input wire logic [2:0] drv_en,
	input wire logic [2:0] drv_val,
	output logic [2:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pad level: device first, then far side, else board pull-up
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : (drv_en[i] ? drv_val[i] : 1'h1);
		end
	end
endmodule : spm_far_dev

// >>> bench/tb_spm_pin_mux.sv
// Self-checking testbench for the serial control pin multiplexer
module tb_spm_pin_mux;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'h0, reset = 1'h1, sm, fso, fsd, fsi;
	logic [2:0] sel, fo, fd, po, pd, de, dv, pi, pq, oe, fi, pti;
	int error_cnt = 0, checks = 0;
	always #20 clock = ~clock;
	spm_pin_mux dut (.clock(clock), .reset(reset), .sync_mode(sm),
		.serial_sel(sel), .flag_out(fo), .flag_dir(fd), .fsync_out(fso),
		.fsync_dir(fsd), .port_out(po), .port_dir(pd), .pin_in(pi),
		.pin_out(pq), .pin_oe(oe), .flag_in(fi), .fsync_in(fsi),
		.port_in(pti));
	spm_far_dev far (.pin_out(pq), .pin_oe(oe), .drv_en(de), .drv_val(dv),
		.pin_in(pi));
	// Compare and count; inputs move only on falling edges
	task chk(input logic [2:0] got, input logic [2:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %b exp %b", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task results;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	//----------------------------------------------------------------
	// Scenarios
	//----------------------------------------------------------------
	// Pins come up released; pulled-up pads read back as port inputs
	task t_reset;
		chk(oe, 3'h0);
		cyc(3);
		chk(pti, 3'h7);
	endtask : t_reset
	// Async mode: control 1 drives frame sync, then receives it
	task t_async;
		sm = 1'h0;
		sel = 3'h2;
		fsd = 1'h1;
		fso = 1'h1;
		cyc(1);
		chk(oe, 3'h2);
		chk(pq & 3'h2, 3'h2);
		// Far side holds control 2 low so only control 1 can give a one
		fsd = 1'h0;
		de = 3'h6;
		dv = 3'h2;
		cyc(1);
		chk(oe, 3'h0);
		cyc(3);
		chk({2'h0, fsi}, 3'h1);
		chk(fi, 3'h0);
		chk(pti, 3'h1);
	endtask : t_async
	// Sync mode: two flags driven independently
	task t_sync;
		sm = 1'h1;
		sel = 3'h3;
		fd = 3'h3;
		fo = 3'h1;
		cyc(1);
		chk(oe, 3'h3);
		chk(pq & 3'h3, 3'h1);
		fo = 3'h2;
		cyc(1);
		chk(pq & 3'h3, 3'h2);
		// Released flags, both driven by the far side, one of the two high at a time
		fd = 3'h0;
		de = 3'h3;
		dv = 3'h1;
		cyc(4);
		chk(oe, 3'h0);
		chk(fi, 3'h1);
		chk(pti, 3'h4);
		dv = 3'h2;
		cyc(4);
		chk(fi, 3'h2);
		chk({2'h0, fsi}, 3'h0);
	endtask : t_sync
	// Port role: flags must not leak onto the port pins
	task t_port;
		sel = 3'h0;
		pd = 3'h6;
		po = 3'h2;
		fd = 3'h7;
		fo = 3'h5;
		fsd = 1'h1;
		cyc(1);
		chk(oe, 3'h6);
		chk(pq & 3'h6, 3'h2);
		cyc(4);
		chk(pti, 3'h2);
		chk(fi, 3'h0);
	endtask : t_port
	// Control 2 as frame sync output, then input
	task t_fs2;
		sm = 1'h0;
		sel = 3'h4;
		pd = 3'h0;
		fd = 3'h0;
		fsd = 1'h1;
		fso = 1'h1;
		cyc(1);
		chk(oe, 3'h4);
		chk(pq & 3'h4, 3'h4);
		// Control 1 held low so a one can only come from control 2
		fsd = 1'h0;
		de = 3'h6;
		dv = 3'h4;
		cyc(4);
		chk(oe, 3'h0);
		chk({2'h0, fsi}, 3'h1);
		chk(pti, 3'h1);
	endtask : t_fs2
	// Mid-run reset while pins drive: everything falls back to inputs
	task t_rerst;
		pd = 3'h7;
		cyc(1);
		chk(oe, 3'h3);
		reset = 1'h1;
		cyc(1);
		chk(oe, 3'h0);
		chk(pq, 3'h0);
		chk(pti, 3'h0);
		chk({2'h0, fsi}, 3'h0);
		sel = 3'h0;
		pd = 3'h0;
		cyc(1);
		reset = 1'h0;
		cyc(2);
		chk(oe, 3'h0);
		cyc(3);
		chk(pti, 3'h5);
	endtask : t_rerst
	initial begin
		{sm, fso, fsd, sel, fo, fd, po, pd, de, dv} = '0;
		cyc(10);
		chk(oe, 3'h0);
		reset = 1'h0;
		cyc(1);
		t_reset();
		t_async();
		t_sync();
		t_port();
		t_fs2();
		t_rerst();
		results();
	end
endmodule : tb_spm_pin_mux
